// File: core/bmd_bus_matrix.sv
`timescale 1ns/1ps
module bmd_bus_matrix #(
  parameter int NUM_MST = bmd_pkg::NUM_MST,
  parameter int NUM_SLV = bmd_pkg::NUM_SLV
) (
  // clock and reset
  input  wire logic                                 CLOCK,
  input  wire logic                                 RST_N,
  // boot, remap and arbitration control
  input  wire logic                                 BOOT_SOURCE_SELECT,
  input  wire logic                                 REMAP_CMD,
  input  wire logic [NUM_SLV-1:0]                   ARB_ROUND_ROBIN,
  // master side
  input  wire bmd_pkg::bmd_mst_req_t [NUM_MST-1:0]  M_REQ,
  output logic [NUM_MST-1:0]                        M_GRANT,
  output logic [NUM_MST-1:0]                        M_ABORT,
  output logic [NUM_MST-1:0][bmd_pkg::SLV_IDX_W-1:0] M_SLAVE,
  // slave side
  output bmd_pkg::bmd_slv_cmd_t [NUM_SLV-1:0]       S_CMD,
  // status
  output logic                                      BOOT_INTERNAL,
  output logic                                      REMAPPED
);
  import bmd_pkg::*;

  // boot select pin: synchroniser and filter
  logic [SYNC_STAGES-1:0] boot_sync;
  logic                   boot_level;
  logic                   next_boot_level;

  always_comb begin
    // a change counts once the last two stages agree
    next_boot_level = boot_level;
    if (boot_sync[1] == boot_sync[2]) begin
      next_boot_level = boot_sync[2];
    end
  end

  // runs through reset so the level is known when reset is released
  always_ff @(posedge CLOCK) begin
    boot_sync  <= {boot_sync[SYNC_STAGES-2:0], BOOT_SOURCE_SELECT};
    boot_level <= next_boot_level;
  end

  // boot source and address map phase
  typedef enum logic [1:0] {
    MAP_BOOT  = 2'b01,
    MAP_REMAP = 2'b10
  } bmd_map_state_t;

  bmd_map_state_t map_state;
  bmd_map_state_t next_map_state;
  logic           next_boot_internal;
  logic           next_remapped;

  always_comb begin
    next_map_state     = map_state;
    next_boot_internal = BOOT_INTERNAL;
    next_remapped      = REMAPPED;
    if (!RST_N) begin
      next_map_state     = MAP_BOOT;
      next_boot_internal = boot_level;
      next_remapped      = REMAP_RST;
    end else begin
      case (map_state)
        MAP_BOOT: begin
          if (REMAP_CMD) begin
            next_map_state = MAP_REMAP;
            next_remapped  = 1'b1;
          end
        end
        MAP_REMAP: begin
          // sticky: only a reset brings the boot memory back to zero
          next_remapped = 1'b1;
        end
        default: begin
          next_map_state = MAP_BOOT;
          next_remapped  = REMAP_RST;
        end
      endcase
    end
  end

  // strap caught during reset, so it is a plain clocked copy
  always_ff @(posedge CLOCK) begin
    map_state     <= next_map_state;
    BOOT_INTERNAL <= next_boot_internal;
    REMAPPED      <= next_remapped;
  end

  // per-master decode
  bmd_route_t           route [NUM_MST];
  logic [NUM_MST-1:0]   live;
  logic [NUM_MST-1:0]   miss;

  genvar gm;
  generate
    for (gm = 0; gm < NUM_MST; gm++) begin : g_dec
      bmd_decoder #(
        .MASTER_ID (gm)
      ) u_dec (
        .addr          (M_REQ[gm].addr),
        .boot_internal (BOOT_INTERNAL),
        .remapped      (REMAPPED),
        .route         (route[gm])
      );
      // a request answered last cycle is not taken twice
      assign live[gm] = M_REQ[gm].valid & ~M_GRANT[gm] & ~M_ABORT[gm];
      assign miss[gm] = live[gm] & ~route[gm].hit;
    end
  endgenerate

  // per-slave request vectors and arbiters
  logic [NUM_MST-1:0] slv_req   [NUM_SLV];
  logic [NUM_MST-1:0] slv_grant [NUM_SLV];

  always_comb begin
    for (int s = 0; s < NUM_SLV; s++) begin
      for (int m = 0; m < NUM_MST; m++) begin
        slv_req[s][m] = live[m] & route[m].hit & (route[m].slave == SLV_IDX_W'(s));
      end
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLV; gs++) begin : g_arb
      bmd_arbiter #(
        .N (NUM_MST)
      ) u_arb (
        .clk         (CLOCK),
        .rst_n       (RST_N),
        .req         (slv_req[gs]),
        .round_robin (ARB_ROUND_ROBIN[gs]),
        .grant       (slv_grant[gs])
      );
    end
  endgenerate

  // master answers
  logic [NUM_MST-1:0]                next_m_grant;
  logic [NUM_MST-1:0]                next_m_abort;
  logic [NUM_MST-1:0][SLV_IDX_W-1:0] next_m_slave;

  always_comb begin
    next_m_grant = '0;
    next_m_abort = '0;
    next_m_slave = M_SLAVE;
    for (int m = 0; m < NUM_MST; m++) begin
      for (int s = 0; s < NUM_SLV; s++) begin
        if (slv_grant[s][m]) begin
          next_m_grant[m] = 1'b1;
          next_m_slave[m] = SLV_IDX_W'(s);
        end
      end
      if (miss[m]) begin
        next_m_abort[m] = 1'b1;
        next_m_slave[m] = route[m].slave;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      M_GRANT <= '0;
      M_ABORT <= '0;
      M_SLAVE <= '0;
    end else begin
      M_GRANT <= next_m_grant;
      M_ABORT <= next_m_abort;
      M_SLAVE <= next_m_slave;
    end
  end

  // slave commands
  bmd_slv_cmd_t [NUM_SLV-1:0] next_s_cmd;

  always_comb begin
    next_s_cmd = '0;
    for (int s = 0; s < NUM_SLV; s++) begin
      for (int m = 0; m < NUM_MST; m++) begin
        if (slv_grant[s][m]) begin
          next_s_cmd[s].valid    = 1'b1;
          next_s_cmd[s].master   = MST_IDX_W'(m);
          next_s_cmd[s].addr     = M_REQ[m].addr;
          next_s_cmd[s].chip_sel = route[m].chip_sel;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      S_CMD <= '0;
    end else begin
      S_CMD <= next_s_cmd;
    end
  end

endmodule

// File: pkg/bmd_pkg.sv
package bmd_pkg;

  // matrix size
  localparam int NUM_MST   = 9;
  localparam int NUM_SLV   = 8;
  localparam int MST_IDX_W = 4;
  localparam int SLV_IDX_W = 3;
  localparam int CS_W      = 4;
  localparam int ADDR_W    = 32;

  // boot pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // 256 Mbyte banks selected by the top address nibble
  localparam int          BANK_LSB        = 28;
  localparam logic [3:0]  BANK_INTERNAL   = 4'h0;
  localparam logic [3:0]  BANK_EXT_FIRST  = 4'h1;
  localparam logic [3:0]  BANK_EXT_A_LAST = 4'h6;
  localparam logic [3:0]  BANK_EXT_B_FIRST = 4'h7;
  localparam logic [3:0]  BANK_EXT_LAST   = 4'h9;
  localparam logic [3:0]  BANK_PERIPH     = 4'hF;

  // 1 Mbyte slots inside the internal bank
  localparam int          SLOT_LSB        = 20;
  localparam logic [7:0]  SLOT_BOOT       = 8'h00;
  localparam logic [7:0]  SLOT_SRAM_FIRST = 8'h01;
  localparam logic [7:0]  SLOT_SRAM_LAST  = 8'h03;
  localparam logic [7:0]  SLOT_ROM        = 8'h04;
  localparam logic [7:0]  SLOT_SRAM_SMALL = 8'h05;
  localparam logic [7:0]  SLOT_CONFIG     = 8'h06;

  // slave ports
  localparam logic [2:0]  SLV_SRAM_LARGE = 3'h0;
  localparam logic [2:0]  SLV_SRAM_SMALL = 3'h1;
  localparam logic [2:0]  SLV_RESERVED   = 3'h2;
  localparam logic [2:0]  SLV_ROM        = 3'h3;
  localparam logic [2:0]  SLV_CONFIG     = 3'h4;
  localparam logic [2:0]  SLV_EXT_A      = 3'h5;
  localparam logic [2:0]  SLV_EXT_B      = 3'h6;
  localparam logic [2:0]  SLV_BRIDGE     = 3'h7;

  // master ports
  localparam int          MST_CPU_INSTR = 0;
  localparam int          MST_CPU_DATA  = 1;

  // which masters are wired to each slave, bit i = master i
  localparam logic [8:0]  ACCESS_ALL    = 9'h1FF;
  localparam logic [8:0]  ACCESS_CPU    = 9'h003;
  localparam logic [8:0]  ACCESS_BRIDGE = 9'h047;
  localparam logic [8:0]  ACCESS_NONE   = 9'h000;

  // reset values
  localparam logic        BOOT_INTERNAL_RST = 1'b1;
  localparam logic        REMAP_RST         = 1'b0;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } bmd_mst_req_t;

  typedef struct packed {
    logic                 hit;
    logic [SLV_IDX_W-1:0] slave;
    logic [CS_W-1:0]      chip_sel;
  } bmd_route_t;

  typedef struct packed {
    logic                 valid;
    logic [MST_IDX_W-1:0] master;
    logic [ADDR_W-1:0]    addr;
    logic [CS_W-1:0]      chip_sel;
  } bmd_slv_cmd_t;

  function automatic logic [8:0] bmd_access_mask(input logic [2:0] slave);
    logic [8:0] m;
    m = ACCESS_NONE;
    if (slave == SLV_CONFIG) begin
      m = ACCESS_CPU;
    end else if (slave == SLV_BRIDGE) begin
      m = ACCESS_BRIDGE;
    end else if (slave != SLV_RESERVED) begin
      m = ACCESS_ALL;
    end
    return m;
  endfunction

  function automatic logic bmd_path_ok(input logic [2:0] slave, input int master);
    logic [8:0] m;
    m = bmd_access_mask(slave);
    return m[master];
  endfunction

endpackage

// File: core/bmd_decoder.sv
`timescale 1ns/1ps
module bmd_decoder #(
  parameter int MASTER_ID = 0
) (
  // request address
  input  wire logic [bmd_pkg::ADDR_W-1:0] addr,
  // boot and remap state
  input  wire logic                       boot_internal,
  input  wire logic                       remapped,
  // decoded route
  output bmd_pkg::bmd_route_t             route
);
  import bmd_pkg::*;

  localparam logic IS_CPU = (MASTER_ID == MST_CPU_INSTR) || (MASTER_ID == MST_CPU_DATA);

  logic [3:0] bank;
  logic [7:0] slot;

  assign bank = addr[BANK_LSB +: 4];
  assign slot = addr[SLOT_LSB +: 8];

  always_comb begin
    route          = '0;
    route.slave    = SLV_RESERVED;
    if (bank == BANK_INTERNAL) begin
      route.hit = 1'b1;
      if (slot == SLOT_BOOT) begin
        if (!IS_CPU) begin
          route.slave = SLV_ROM;
        end else if (remapped) begin
          route.slave = SLV_SRAM_LARGE;
        end else if (boot_internal) begin
          route.slave = SLV_ROM;
        end else begin
          route.slave = SLV_EXT_A;
        end
      end else if (slot >= SLOT_SRAM_FIRST && slot <= SLOT_SRAM_LAST) begin
        route.slave = SLV_SRAM_LARGE;
      end else if (slot == SLOT_ROM) begin
        route.slave = SLV_ROM;
      end else if (slot == SLOT_SRAM_SMALL) begin
        route.slave = SLV_SRAM_SMALL;
      end else if (slot == SLOT_CONFIG) begin
        route.slave = SLV_CONFIG;
      end else begin
        route.hit = 1'b0;
      end
    end else if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_A_LAST) begin
      route.hit      = 1'b1;
      route.slave    = SLV_EXT_A;
      route.chip_sel = bank - BANK_EXT_FIRST;
    end else if (bank >= BANK_EXT_B_FIRST && bank <= BANK_EXT_LAST) begin
      route.hit      = 1'b1;
      route.slave    = SLV_EXT_B;
      route.chip_sel = bank - BANK_EXT_B_FIRST;
    end else if (bank == BANK_PERIPH) begin
      route.hit   = 1'b1;
      route.slave = SLV_BRIDGE;
    end
    // unwired or reserved path answers like unused space
    if (!bmd_path_ok(route.slave, MASTER_ID)) begin
      route.hit = 1'b0;
    end
  end

endmodule

// File: core/bmd_arbiter.sv
`timescale 1ns/1ps
module bmd_arbiter #(
  parameter int N = 9
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // requests and scheme
  input  wire logic [N-1:0] req,
  input  wire logic         round_robin,
  // one-hot grant
  output logic      [N-1:0] grant
);
  import bmd_pkg::*;

  logic [MST_IDX_W-1:0] last;
  logic [MST_IDX_W-1:0] next_last;

  always_comb begin
    int   idx;
    logic found;
    idx       = 0;
    found     = 1'b0;
    grant     = '0;
    next_last = last;
    for (int k = 0; k < N; k++) begin
      // fixed: lowest index wins; round robin: start after the last winner
      idx = round_robin ? ((int'(last) + 1 + k) % N) : k;
      if (!found && req[idx]) begin
        found          = 1'b1;
        grant[idx]     = 1'b1;
        next_last      = MST_IDX_W'(idx);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last <= MST_IDX_W'(N - 1);
    end else begin
      last <= next_last;
    end
  end

endmodule

// File: tb/bmd_bus_matrix_asserts.sv
`timescale 1ns/1ps
module bmd_bus_matrix_asserts import bmd_pkg::*; #(
  parameter int NUM_MST = 9,
  parameter int NUM_SLV = 8
) (
  // clock and reset
  input wire logic                                  CLOCK,
  input wire logic                                  RST_N,
  // boot and remap
  input wire logic                                  REMAP_CMD,
  input wire logic                                  BOOT_INTERNAL,
  input wire logic                                  REMAPPED,
  // buses
  input wire bmd_pkg::bmd_mst_req_t [NUM_MST-1:0]   M_REQ,
  input wire logic [NUM_MST-1:0]                    M_GRANT,
  input wire logic [NUM_MST-1:0]                    M_ABORT,
  input wire bmd_pkg::bmd_slv_cmd_t [NUM_SLV-1:0]   S_CMD
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_abort_pulse: assert property ((M_ABORT & $past(M_ABORT)) == '0)
    else $error("abort held two cycles");
  a_unused_bank: assert property (M_REQ[1].valid && !M_GRANT[1] && !M_ABORT[1]
    && M_REQ[1].addr[31:28] inside {[4'hA:4'hE]} |=> M_ABORT[1])
    else $error("unused bank not aborted");
  a_bridge_path: assert property (M_REQ[3].valid && !M_GRANT[3] && !M_ABORT[3]
    && M_REQ[3].addr[31:28] == 4'hF |=> M_ABORT[3])
    else $error("bridge reached by display master");
  a_config_path: assert property (M_REQ[8].valid && !M_GRANT[8] && !M_ABORT[8]
    && M_REQ[8].addr[31:20] == 12'h006 |=> M_ABORT[8])
    else $error("config slave reached by host master");
  a_ext_a_cs: assert property (S_CMD[5].valid && S_CMD[5].addr[31:28] != 4'h0
    |-> S_CMD[5].chip_sel == S_CMD[5].addr[31:28] - 4'h1)
    else $error("first interface chip select wrong");
  a_ext_b_cs: assert property (S_CMD[6].valid
    |-> S_CMD[6].chip_sel == S_CMD[6].addr[31:28] - 4'h7)
    else $error("second interface chip select wrong");
  a_bridge_bank: assert property (S_CMD[7].valid |-> S_CMD[7].addr[31:28] == 4'hF)
    else $error("bridge command outside its bank");
  a_reserved_idle: assert property (!S_CMD[2].valid)
    else $error("reserved slave commanded");
  a_boot_frozen: assert property ($past(RST_N) |-> $stable(BOOT_INTERNAL))
    else $error("boot level moved outside reset");
  a_remap_sticky: assert property (REMAPPED |=> REMAPPED)
    else $error("remap state dropped");
  a_remap_set: assert property (REMAP_CMD |-> ##[1:2] REMAPPED)
    else $error("remap command ignored");
endmodule

bind bmd_bus_matrix bmd_bus_matrix_asserts #(.NUM_MST(NUM_MST), .NUM_SLV(NUM_SLV)) u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .REMAP_CMD(REMAP_CMD), .BOOT_INTERNAL(BOOT_INTERNAL),
  .REMAPPED(REMAPPED), .M_REQ(M_REQ), .M_GRANT(M_GRANT), .M_ABORT(M_ABORT), .S_CMD(S_CMD));

// File: tb/bmd_master_model.sv
`timescale 1ns/1ps
module bmd_master_model import bmd_pkg::*; (
  input wire logic        clk,
  input wire logic        rst_n,
  // command from the bench
  input wire logic        start,
  input wire logic [31:0] addr_in,
  input wire logic [3:0]  lag,
  // bus side
  output bmd_pkg::bmd_mst_req_t req,
  input wire logic        grant,
  input wire logic        abort
);
  logic [3:0]  wait_cnt;
  logic        pend;
  logic [31:0] addr_hold;

  // valid held until answered; address scrambled when idle so no stale match
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req <= '0;
      pend <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (start) begin
      pend <= 1'b1;
      wait_cnt <= lag;
      addr_hold <= addr_in;
    end else if (pend && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (pend) begin
      req <= '{valid: 1'b1, addr: addr_hold};
      pend <= 1'b0;
    end else if (req.valid && (grant || abort)) begin
      req <= '{valid: 1'b0, addr: ~req.addr};
    end
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
  import bmd_pkg::*;
  logic CLOCK = 0, RST_N = 0, BOOT_SOURCE_SELECT = 1, REMAP_CMD = 0;
  logic [7:0] ARB_ROUND_ROBIN = 8'h00;
  wire bmd_mst_req_t [8:0] M_REQ;
  logic [8:0] M_GRANT, M_ABORT;
  logic [8:0][2:0] M_SLAVE;
  bmd_slv_cmd_t [7:0] S_CMD;
  logic BOOT_INTERNAL, REMAPPED;
  logic [8:0] start = '0;
  logic [8:0][31:0] addr_in = '0;
  logic [8:0][3:0] lag = '0;
  int num_errors = 0, samples_checked = 0;

  initial forever #4 CLOCK = ~CLOCK;

  for (genvar i = 0; i < 9; i++) begin : g_m
    bmd_master_model u_m (.clk(CLOCK), .rst_n(RST_N), .start(start[i]), .addr_in(addr_in[i]),
      .lag(lag[i]), .req(M_REQ[i]), .grant(M_GRANT[i]), .abort(M_ABORT[i]));
  end

  bmd_bus_matrix dut (.CLOCK(CLOCK), .RST_N(RST_N), .BOOT_SOURCE_SELECT(BOOT_SOURCE_SELECT),
    .REMAP_CMD(REMAP_CMD), .ARB_ROUND_ROBIN(ARB_ROUND_ROBIN), .M_REQ(M_REQ),
    .M_GRANT(M_GRANT), .M_ABORT(M_ABORT), .M_SLAVE(M_SLAVE), .S_CMD(S_CMD),
    .BOOT_INTERNAL(BOOT_INTERNAL), .REMAPPED(REMAPPED));

  task automatic do_reset(input logic bss);
    @(posedge CLOCK);
    RST_N <= 1'b0;
    BOOT_SOURCE_SELECT <= bss;
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
  endtask

  task automatic acc(input int m, input logic [31:0] a, input logic ab, input logic [2:0] s,
                     input logic [3:0] cs);
    logic [40:0] got;
    @(posedge CLOCK);
    start[m] <= 1'b1;
    addr_in[m] <= a;
    @(posedge CLOCK);
    start[m] <= 1'b0;
    repeat (30) begin
      @(posedge CLOCK);
      #1;
      if (M_GRANT[m] || M_ABORT[m]) break;
    end
    `CHK(M_GRANT[m] | M_ABORT[m], 1'b1)
    `CHK({M_ABORT[m], M_SLAVE[m]}, {ab, s})
    got = {S_CMD[s].valid, S_CMD[s].master, S_CMD[s].addr, S_CMD[s].chip_sel};
    if (!ab) `CHK(got, {1'b1, 4'(m), a, cs})
  endtask

  task automatic bank_sweep;
    logic [3:0] b;
    for (int i = 0; i < 16; i++) begin
      b = 4'(i);
      acc(1, {b, 28'h0100000}, b > 9 && b < 15,
          b == 0 ? 3'h0 : b < 7 ? 3'h5 : b < 10 ? 3'h6 : b == 15 ? 3'h7 : 3'h2,
          b > 0 && b < 7 ? b - 4'h1 : b > 6 && b < 10 ? b - 4'h7 : 4'h0);
    end
    acc(1, 32'h0070_0000, 1'b1, 3'h2, 4'h0);
  endtask

  task automatic path_matrix;
    for (int m = 0; m < 9; m++) begin
      lag[m] <= 4'(m % 3);
      acc(m, 32'h0060_0000, m > 1, 3'h4, 4'h0);
      acc(m, 32'hF000_0000, !(m inside {0, 1, 2, 6}), 3'h7, 4'h0);
      acc(m, 32'h0040_0000, 1'b0, 3'h3, 4'h0);
      acc(m, 32'h0050_0000, 1'b0, 3'h1, 4'h0);
      acc(m, 32'h6000_0000, 1'b0, 3'h5, 4'h5);
      lag[m] <= 4'h0;
    end
  endtask

  task automatic boot_remap;
    do_reset(1'b1);
    `CHK(BOOT_INTERNAL, 1'b1)
    acc(0, 32'h0, 1'b0, 3'h3, 4'h0);
    do_reset(1'b0);
    BOOT_SOURCE_SELECT <= 1'b1;
    // long enough for the pin change to pass the synchroniser
    repeat (6) @(posedge CLOCK);
    `CHK(BOOT_INTERNAL, 1'b0)
    acc(1, 32'h0, 1'b0, 3'h5, 4'h0);
    acc(2, 32'h0, 1'b0, 3'h3, 4'h0);
    @(posedge CLOCK);
    REMAP_CMD <= 1'b1;
    @(posedge CLOCK);
    REMAP_CMD <= 1'b0;
    repeat (2) @(posedge CLOCK);
    `CHK(REMAPPED, 1'b1)
    acc(0, 32'h0, 1'b0, 3'h0, 4'h0);
    acc(4, 32'h0, 1'b0, 3'h3, 4'h0);
  endtask

  // master 4 wins alone first, then all nine masters hit the ROM in the same cycle
  task automatic contend(input logic rr);
    int first, cnt;
    first = -1;
    cnt = 0;
    @(posedge CLOCK);
    ARB_ROUND_ROBIN <= {4'h0, rr, 3'h0};
    acc(4, 32'h0040_0000, 1'b0, 3'h3, 4'h0);
    @(posedge CLOCK);
    start <= '1;
    addr_in <= {9{32'h0040_0000}};
    @(posedge CLOCK);
    start <= '0;
    repeat (40) begin
      @(posedge CLOCK);
      #1;
      cnt += $countones(M_GRANT);
      if (first < 0 && M_GRANT != '0) first = $clog2(M_GRANT & -M_GRANT);
    end
    `CHK(cnt, 9)
    `CHK(first, rr ? 5 : 0)
  endtask

  task automatic give_verdict;
    $display("checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    do_reset(1'b1);
    bank_sweep();
    path_matrix();
    contend(1'b0);
    contend(1'b1);
    boot_remap();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge CLOCK);
    num_errors++;
    give_verdict();
  end
endmodule
